// ==== testbench/acc_analog_core_model.sv ====
// Model of the analog core feeding result bits to the control block.
// Assumes the bench sets the next value before each start sequence.
module acc_analog_core_model (
  input wire logic       ref_clk,
  input wire logic       conv_power,
  input wire logic       conv_reset,
  input wire logic [8:0] next_val,
  output logic     [8:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] held_reg;
  // New sample taken at each converter reset
  always_ff @(posedge ref_clk) begin
    if (conv_reset) begin
      held_reg <= next_val;
    end
  end
  // Powered off: lines churn instead of holding
  always_ff @(posedge ref_clk) begin
    conv_data <= conv_power ? held_reg : ~conv_data;
  end
endmodule : acc_analog_core_model

// ==== testbench/acc_control_monitor.sv ====
// Checker on the converter control ports.
// Assumes one clock and a synchronous active-low reset.
module acc_control_monitor (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] analog_channel,
  input wire logic [3:0] port_b_analog,
  input wire logic       conv_power,
  input wire logic       conv_sampling,
  input wire logic       conv_reset,
  input wire logic       conv_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [7:0]  ie_reg;
  logic [1:0]  sel_reg;
  logic [11:0] cnt_reg;
  int          div;
  wire         ctl_wr = reg_wr && reg_addr == acc_pkg::CONTROL_ADDR;
  // Shadow of enables and divider code
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ie_reg  <= 8'h00;
      sel_reg <= 2'h0;
    end else if (reg_wr && reg_addr == acc_pkg::INT_CONTROL_ADDR) begin
      ie_reg <= reg_wdata;
    end else if (reg_wr && reg_addr == acc_pkg::CLOCK_SEL_ADDR) begin
      sel_reg <= reg_wdata[1:0];
    end
  end
  // Length of the sampling phase in system cycles
  always_ff @(posedge ref_clk) begin
    cnt_reg <= (!reset_n || !conv_sampling) ? 12'h000 : cnt_reg + 12'h001;
  end
  // Divider in system cycles
  always_comb begin
    div = (sel_reg == 2'h1) ? 8 : (sel_reg == 2'h2) ? 32 : 2;
  end
  function automatic logic [3:0] pb(input logic [2:0] c);
    return c[2] ? 4'hf : 4'((5'h01 << c[1:0]) - 5'h01);
  endfunction : pb
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_reset_pulse;
    conv_reset |-> ($past(ctl_wr && reg_wdata[7]) || $past(ctl_wr && reg_wdata[7], 2))
      ##1 !conv_reset;
  endproperty
  property p_irq_pulse;
    conv_irq |=> !conv_irq;
  endproperty
  property p_irq_en;
    conv_irq |-> ie_reg[0] && ie_reg[3];
  endproperty
  property p_power;
    ctl_wr |-> ##2 conv_power == (|$past(reg_wdata[5:3], 2));
  endproperty
  property p_port_b;
    ctl_wr |-> ##2 port_b_analog == pb($past(reg_wdata[5:3], 2));
  endproperty
  property p_chan;
    ctl_wr |-> ##2 analog_channel == $past(reg_wdata[1:0], 2);
  endproperty
  property p_samp_len;
    $fell(conv_sampling) |-> cnt_reg >= 32 * div - 2 && cnt_reg <= 32 * div + 2;
  endproperty
  property p_csel_rd;
    reg_rd && reg_addr == acc_pkg::CLOCK_SEL_ADDR |=> reg_rdata[6:2] == 5'h00;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse wrong");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
  a_power: assert property (p_power) else $error("power wrong");
  a_port_b: assert property (p_port_b) else $error("port b config wrong");
  a_chan: assert property (p_chan) else $error("channel wrong");
  a_samp_len: assert property (p_samp_len) else $error("sampling length wrong");
  a_csel_rd: assert property (p_csel_rd) else $error("unused bits set");
  c_irq: cover property (conv_irq);
  c_samp: cover property ($fell(conv_sampling));
  c_reset: cover property (conv_reset);
endmodule : acc_control_monitor

// ==== testbench/adc_conversion_control_tb_top.sv ====
// Bench for the converter control block, 8-bit and 9-bit variants side by side.
// Assumes the monitor and analog core model compiled before it.
module adc_conversion_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk, reset_n, reg_wr, reg_rd, conv_power, conv_sampling, conv_reset, conv_irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, reg_rdata2, d, d2, e;
  logic [8:0] conv_data, conv_data2, next_val, e9;
  logic       conv_power2, conv_reset2;
  logic [1:0] analog_channel;
  logic [3:0] port_b_analog;
  logic [7:0] ie[3] = '{8'h00, 8'h01, 8'h09};
  logic [8:0] exp_q[$];
  int         n_mismatch, n_checks, cyc, n_irq, exp_irq;
  int         seed = 32'h077f;
  acc_control #(.NINE_BIT(1'b0)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conv_data(conv_data), .analog_channel(analog_channel), .port_b_analog(port_b_analog),
    .conv_power(conv_power), .conv_sampling(conv_sampling), .conv_reset(conv_reset),
    .conv_irq(conv_irq));
  acc_analog_core_model core (.ref_clk(ref_clk), .conv_power(conv_power),
    .conv_reset(conv_reset), .next_val(next_val), .conv_data(conv_data));
  acc_control #(.NINE_BIT(1'b1)) dut_nine (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata2), .conv_data(conv_data2), .analog_channel(), .port_b_analog(),
    .conv_power(conv_power2), .conv_sampling(), .conv_reset(conv_reset2), .conv_irq());
  acc_analog_core_model core_nine (.ref_clk(ref_clk), .conv_power(conv_power2),
    .conv_reset(conv_reset2), .next_val(next_val), .conv_data(conv_data2));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Cycle count, interrupt count and hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (conv_irq === 1'b1) n_irq++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = v;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d      = reg_rdata;
    d2     = reg_rdata2;
  endtask : rd
  task automatic chk(input logic [8:0] got, input logic [8:0] want);
    n_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // One polled conversion at divider code c
  task automatic conv(input int c);
    int n;
    int t0;
    n        = (c == 1) ? 8 : (c == 2) ? 32 : 2;
    next_val = 9'($random(seed));
    exp_q.push_back(next_val);
    if (c == 2) exp_irq++;
    wr(acc_pkg::CLOCK_SEL_ADDR, 8'(c));
    wr(acc_pkg::INT_CONTROL_ADDR, ie[c]);
    wr(acc_pkg::CONTROL_ADDR, 8'h20);
    @(negedge ref_clk);
    chk(9'({conv_power, port_b_analog, analog_channel}), 9'h07c);
    wr(acc_pkg::CONTROL_ADDR, 8'ha0);
    wr(acc_pkg::CONTROL_ADDR, 8'h20);
    t0 = cyc;
    rd(acc_pkg::CONTROL_ADDR);
    chk(9'(d[6]), 9'h001);
    for (int i = 0; i < 2000 && d[6] !== 1'b0; i++) rd(acc_pkg::CONTROL_ADDR);
    chk(9'(cyc - t0 >= 64 * n - 4 && cyc - t0 <= 64 * n + 6), 9'h001);
    e9 = exp_q.pop_front();
    next_val = ~next_val;
    rd(acc_pkg::RESULT_HIGH_ADDR);
    chk(9'(d), 9'(e9[7:0]));
    rd(acc_pkg::RESULT_LOW_ADDR);
    chk(9'(d), 9'h000);
    rd(acc_pkg::RESULT_HIGH_ADDR);
    chk(9'(d), 9'(e9[7:0]));
    // 9-bit variant ends later: poll its flag, then its byte pair
    rd(acc_pkg::CONTROL_ADDR);
    for (int i = 0; i < 2000 && d2[6] !== 1'b0; i++) rd(acc_pkg::CONTROL_ADDR);
    chk(9'(cyc - t0 >= 76 * n - 4 && cyc - t0 <= 76 * n + 6), 9'h001);
    rd(acc_pkg::RESULT_HIGH_ADDR);
    e = d2;
    rd(acc_pkg::RESULT_LOW_ADDR);
    chk({e, d2[7]}, e9);
    chk(9'(d2[6:0]), 9'h000);
    chk(9'(n_irq), 9'(exp_irq));
    $display("conversion at code %0d done", c);
  endtask : conv
  // Main sequence
  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, next_val} = '0;
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    rd(acc_pkg::CONTROL_ADDR);
    chk(9'(d), 9'h041);
    rd(acc_pkg::CLOCK_SEL_ADDR);
    chk(9'(d), 9'h000);
    wr(acc_pkg::CLOCK_SEL_ADDR, 8'h7f);
    rd(acc_pkg::CLOCK_SEL_ADDR);
    chk(9'(d[6:0]), 9'h003);
    wr(acc_pkg::CLOCK_SEL_ADDR, 8'h01);
    rd(acc_pkg::CLOCK_SEL_ADDR);
    chk(9'(d[6:0]), 9'h001);
    $display("register test done");
    for (int c = 0; c < 3; c++) conv(c);
    // Next start sequence after a serviced interrupt
    conv(2);
    for (int p = 0; p < 5; p++) begin
      e = 8'({p[2:0], 1'b0, 2'($random(seed))});
      wr(acc_pkg::CONTROL_ADDR, e);
      @(negedge ref_clk);
      chk(9'(port_b_analog), 9'(p == 4 ? 4'hf : 4'((1 << p) - 1)));
      chk(9'({conv_power, analog_channel}), 9'({p != 0, e[1:0]}));
    end
    $display("config test done");
    wr(acc_pkg::CLOCK_SEL_ADDR, 8'h00);
    wr(acc_pkg::CONTROL_ADDR, 8'h80);
    wr(acc_pkg::CONTROL_ADDR, 8'h00);
    repeat (140) @(negedge ref_clk);
    rd(acc_pkg::CONTROL_ADDR);
    chk(9'(d[6]), 9'h001);
    $display("powered off start test done");
    results();
  end
endmodule : adc_conversion_control_tb_top
bind acc_control acc_control_monitor mon (.ref_clk(ref_clk), .reset_n(reset_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .analog_channel(analog_channel), .port_b_analog(port_b_analog),
  .conv_power(conv_power), .conv_sampling(conv_sampling), .conv_reset(conv_reset),
  .conv_irq(conv_irq));

// ==== verilog/acc_clock_divider.sv ====
// Converter clock divider: one-cycle tick per converter clock period.
// Assumes the selection code is held stable while a conversion runs.
module acc_clock_divider (
  input wire logic ref_clk,
  input wire logic reset_n,
  acc_tick_if.div  tick_port
);

  logic [4:0] count_reg;
  logic [4:0] limit;
  logic       tick_reg;

  // Terminal count from the selected divide ratio
  always_comb begin
    unique case (tick_port.clk_sel)
      acc_pkg::CLK_DIV8:  limit = 5'(acc_pkg::DIV8_PERIODS - 1);
      acc_pkg::CLK_DIV32: limit = 5'(acc_pkg::DIV32_PERIODS - 1);
      default:            limit = 5'(acc_pkg::DIV2_PERIODS - 1);
    endcase
  end

  // Free divider, realigned on restart
  always_ff @(posedge ref_clk) begin
    if (!reset_n || tick_port.restart) begin
      count_reg <= 5'h0;
      tick_reg  <= 1'b0;
    end else if (count_reg >= limit) begin
      count_reg <= 5'h0;
      tick_reg  <= 1'b1;
    end else begin
      count_reg <= count_reg + 5'h1;
      tick_reg  <= 1'b0;
    end
  end

  assign tick_port.tick = tick_reg;

endmodule : acc_clock_divider

// ==== verilog/acc_control.sv ====
// Digital control of a four-channel successive-approximation converter.
// Assumes a byte-wide special register port on ref_clk and an analog core
// that presents its result bits on conv_data while a conversion runs.
//
// Overview of operation
// - Converter clock is system clock over 2, 8 or 32 only.
// - 8-bit variant finishes 64 converter periods after start.
// - 9-bit variant finishes 76 converter periods after start.
// - Sampling lasts 32 converter periods at the start of each conversion.
// - Interrupt needs global enable bit 0 and converter enable bit 3.
// - Writing 00100000B makes all port-B lines analog, channel 0.
// - Writing 00000001B to clock select chooses system clock over 8.
// - At completion flag clears and enabled interrupt is requested.
// - Channel codes 000 to 011 pick inputs 0 to 3.
// - Config field makes 0 to 4 lines analog; 000 powers off.
// - Clock select 00, 01, 10 give over 2, 8, 32.
module acc_control #(
  parameter bit NINE_BIT = 1'b0
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [8:0] conv_data,
  output logic      [1:0] analog_channel,
  output logic      [3:0] port_b_analog,
  output logic            conv_power,
  output logic            conv_sampling,
  output logic            conv_reset,
  output logic            conv_irq
);

  // ----------------------------------------
  // Registers and sequencer state
  // ----------------------------------------
  logic [7:0]        conv_control_reg;
  logic [7:0]        conv_clock_select_reg;
  logic [7:0]        interrupt_control_reg;
  logic [8:0]        result_reg;
  logic [7:0]        reg_rdata_reg;
  logic [3:0]        port_b_analog_reg;
  logic [1:0]        analog_channel_reg;
  logic              conv_power_reg;
  logic              conv_sampling_reg;
  logic              conv_reset_reg;
  logic              conv_irq_reg;
  logic [6:0]        period_reg;
  acc_pkg::acc_state_e state_reg;
  logic              ctrl_wr;
  logic              start_rise;
  logic              start_fall;
  logic [6:0]        last_period;
  logic [2:0]        pcfg;
  logic [7:0]        d_in;
  acc_tick_if        tick_port ();

  // Decoded control write and start bit edges
  assign ctrl_wr    = reg_wr && (reg_addr == acc_pkg::CONTROL_ADDR);
  assign start_rise = ctrl_wr && !conv_control_reg[acc_pkg::START_BIT]
                      && reg_wdata[acc_pkg::START_BIT];
  assign start_fall = ctrl_wr && conv_control_reg[acc_pkg::START_BIT]
                      && !reg_wdata[acc_pkg::START_BIT];
  assign last_period = NINE_BIT ? 7'(acc_pkg::CONV_PERIODS_9 - 1)
                                : 7'(acc_pkg::CONV_PERIODS_8 - 1);
  assign pcfg = conv_control_reg[acc_pkg::PCFG_MSB:acc_pkg::PCFG_LSB];
  assign d_in = reg_wdata;

  // ----------------------------------------
  // Converter clock divider
  // ----------------------------------------
  assign tick_port.clk_sel = conv_clock_select_reg[acc_pkg::CLK_SEL_MSB:0];
  assign tick_port.restart = start_fall;

  acc_clock_divider u_divider (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .tick_port (tick_port)
  );

  // Control register: channel, port config, start, completion flag
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      conv_control_reg <= acc_pkg::CONTROL_RESET;
    end else begin
      if (ctrl_wr) begin
        conv_control_reg[acc_pkg::START_BIT] <= d_in[acc_pkg::START_BIT];
        conv_control_reg[acc_pkg::PCFG_MSB:acc_pkg::CHAN_LSB] <=
          d_in[acc_pkg::PCFG_MSB:acc_pkg::CHAN_LSB];
      end
      if (start_rise) begin
        conv_control_reg[acc_pkg::DONE_N_BIT] <= 1'b1;
      end else if (state_reg == acc_pkg::ACC_CONV && tick_port.tick
                   && period_reg == last_period) begin
        conv_control_reg[acc_pkg::DONE_N_BIT] <= 1'b0;
      end
    end
  end

  // Clock select and interrupt control registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      conv_clock_select_reg <= acc_pkg::CLOCK_SEL_RESET;
      interrupt_control_reg <= acc_pkg::INT_CTRL_RESET;
    end else if (reg_wr && reg_addr == acc_pkg::CLOCK_SEL_ADDR) begin
      conv_clock_select_reg <= {d_in[acc_pkg::TEST_BIT], 5'h00,
                                d_in[acc_pkg::CLK_SEL_MSB:0]};
    end else if (reg_wr && reg_addr == acc_pkg::INT_CONTROL_ADDR) begin
      interrupt_control_reg <= d_in;
    end
  end

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n || start_rise) begin
      state_reg  <= acc_pkg::ACC_IDLE;
      period_reg <= 7'h00;
    end else begin
      unique case (state_reg)
        acc_pkg::ACC_IDLE: begin
          period_reg <= 7'h00;
          if (start_fall && pcfg != acc_pkg::PCFG_OFF) begin
            state_reg <= acc_pkg::ACC_SAMPLE;
          end
        end
        acc_pkg::ACC_SAMPLE: begin
          if (tick_port.tick) begin
            period_reg <= period_reg + 7'h01;
            if (period_reg == 7'(acc_pkg::SAMPLE_PERIODS - 1)) begin
              state_reg <= acc_pkg::ACC_CONV;
            end
          end
        end
        acc_pkg::ACC_CONV: begin
          if (tick_port.tick) begin
            period_reg <= period_reg + 7'h01;
            if (period_reg == last_period) begin
              state_reg <= acc_pkg::ACC_IDLE;
            end
          end
        end
        default: begin
          state_reg <= acc_pkg::ACC_IDLE;
        end
      endcase
    end
  end

  // Result capture only at completion
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      result_reg <= 9'h000;
    end else if (state_reg == acc_pkg::ACC_CONV && tick_port.tick
                 && period_reg == last_period) begin
      result_reg <= NINE_BIT ? conv_data : {1'b0, conv_data[7:0]};
    end
  end

  // Interrupt request at completion when both enables set
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      conv_irq_reg <= 1'b0;
    end else begin
      conv_irq_reg <= state_reg == acc_pkg::ACC_CONV && tick_port.tick
                      && period_reg == last_period
                      && interrupt_control_reg[acc_pkg::GLOBAL_IE_BIT]
                      && interrupt_control_reg[acc_pkg::CONV_IE_BIT];
    end
  end

  // ----------------------------------------
  // Analog side controls
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      analog_channel_reg <= 2'h0;
      port_b_analog_reg  <= 4'h0;
      conv_power_reg     <= 1'b0;
      conv_sampling_reg  <= 1'b0;
      conv_reset_reg     <= 1'b0;
    end else begin
      // Top channel bit set is unusable; low bits still drive the mux
      analog_channel_reg <= conv_control_reg[acc_pkg::CHAN_LSB+1:acc_pkg::CHAN_LSB];
      unique case (pcfg)
        3'h0:    port_b_analog_reg <= 4'h0;
        3'h1:    port_b_analog_reg <= 4'h1;
        3'h2:    port_b_analog_reg <= 4'h3;
        3'h3:    port_b_analog_reg <= 4'h7;
        default: port_b_analog_reg <= 4'hF;
      endcase
      conv_power_reg    <= pcfg != acc_pkg::PCFG_OFF;
      conv_sampling_reg <= state_reg == acc_pkg::ACC_SAMPLE;
      conv_reset_reg    <= start_rise;
    end
  end

  // Read data mux, registered
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        acc_pkg::CONTROL_ADDR:     reg_rdata_reg <= conv_control_reg;
        acc_pkg::CLOCK_SEL_ADDR:   reg_rdata_reg <= conv_clock_select_reg;
        acc_pkg::INT_CONTROL_ADDR: reg_rdata_reg <= interrupt_control_reg;
        acc_pkg::RESULT_HIGH_ADDR:
          reg_rdata_reg <= NINE_BIT ? result_reg[8:1] : result_reg[7:0];
        acc_pkg::RESULT_LOW_ADDR:
          reg_rdata_reg <= NINE_BIT ? {result_reg[0], 7'h00} : 8'h00;
        default:                   reg_rdata_reg <= 8'h00;
      endcase
    end
  end

  assign reg_rdata      = reg_rdata_reg;
  assign analog_channel = analog_channel_reg;
  assign port_b_analog  = port_b_analog_reg;
  assign conv_power     = conv_power_reg;
  assign conv_sampling  = conv_sampling_reg;
  assign conv_reset     = conv_reset_reg;
  assign conv_irq       = conv_irq_reg;

endmodule : acc_control

// ==== verilog/acc_pkg.sv ====
// Constants for the converter control block: register offsets, fields, timing.
// Assumes a single system clock domain and a byte-wide special register port.
package acc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] RESULT_LOW_ADDR    = 8'h20;
  localparam logic [7:0] RESULT_HIGH_ADDR   = 8'h21;
  localparam logic [7:0] CONTROL_ADDR       = 8'h22;
  localparam logic [7:0] CLOCK_SEL_ADDR     = 8'h23;
  localparam logic [7:0] INT_CONTROL_ADDR   = 8'h0B;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CHAN_LSB       = 0;
  localparam int CHAN_MSB       = 2;
  localparam int PCFG_LSB       = 3;
  localparam int PCFG_MSB       = 5;
  localparam int DONE_N_BIT     = 6;
  localparam int START_BIT      = 7;
  localparam int CLK_SEL_MSB    = 1;
  localparam int TEST_BIT       = 7;
  localparam int GLOBAL_IE_BIT  = 0;
  localparam int CONV_IE_BIT    = 3;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [7:0] CONTROL_RESET   = 8'h41;
  localparam logic [7:0] CLOCK_SEL_RESET = 8'h00;
  localparam logic [7:0] INT_CTRL_RESET  = 8'h00;
  localparam logic [1:0] CLK_DIV2        = 2'h0;
  localparam logic [1:0] CLK_DIV8        = 2'h1;
  localparam logic [1:0] CLK_DIV32       = 2'h2;
  localparam logic [2:0] PCFG_OFF        = 3'h0;

  // ----------------------------------------
  // Timing: divide ratios in system cycles, phases in converter periods
  // ----------------------------------------
  localparam int DIV2_PERIODS    = 2;
  localparam int DIV8_PERIODS    = 8;
  localparam int DIV32_PERIODS   = 32;
  localparam int CONV_PERIODS_8  = 64;
  localparam int CONV_PERIODS_9  = 76;
  localparam int SAMPLE_PERIODS  = 32;

  // Converter sequencer states
  typedef enum logic [2:0] {
    ACC_IDLE   = 3'b001,
    ACC_SAMPLE = 3'b010,
    ACC_CONV   = 3'b100
  } acc_state_e;

endpackage : acc_pkg

// ==== verilog/acc_tick_if.sv ====
// Carrier between the control logic and its converter clock divider.
// Assumes both ends run on the same system clock.
interface acc_tick_if;
  logic [1:0] clk_sel;
  logic       restart;
  logic       tick;

  modport ctrl (output clk_sel, output restart, input tick);
  modport div  (input clk_sel, input restart, output tick);
endinterface : acc_tick_if
